// ==== core/ssd_port.sv ====
// Synchronous serial data port: registers, shifter, pins, power modes
//
// Behaviour
// - Eighth rising edge latches auxiliary pin level
// - Reset clears auxiliary capture bit
// - One 8-bit data register at 0x0C
// - Data writes during transfer are ignored
// - Data reads harmless, may show partial byte
// - Stop halts master shifting; master pins keep their levels
// - Slave keeps shifting on external clock in stop
// - No interrupt request while stopped
// - Done flag survives stop; request after exit
// - Port keeps running; interrupt wakes from wait
// - Enabled port overrides port B directions 3-5
// - Stored port B directions never modified
// - Done flag sets last rise; clears by sequence
// - Clash flag on data access mid-transfer
// - Disable aborts transfer, clears counter, floats pins
// - Sample on rising edge, shift on falling
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ssd_port
  import ssd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_mode,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  input  wire logic        aux_sample_pin,
  input  wire logic [7:0]  portb_ddr,
  output logic      [7:0]  portb_dir,
  output logic             irq
);

  logic [7:0]  ctrl, next_ctrl;
  logic        sf, next_sf, access_clash_flag, next_access_clash_flag;
  logic        aux_cap, next_aux_cap, clr_arm, next_clr_arm;
  logic [7:0]  shift_data_reg, next_sdr;
  logic        sdio_q, next_sdio_q, sck_q, next_sck_q;
  logic        fell_seen, next_fell_seen;
  logic [3:0]  bit_cnt, next_bit_cnt, div_cnt, next_div_cnt;
  logic [3:0]  half_m1;
  ssd_state_t  st, next_st;
  logic [31:0] next_prdata;
  logic [2:0]  sync_q;
  logic        sck_s, sdio_s, aux_s, ext_rise, ext_fall;
  logic        acc, wr, rd, hit_ctrl, hit_stat, hit_data, data_acc;
  logic        tick, ev_rise, ev_fall, slv_start, start, abort;
  logic        act_rise, act_fall, tail_end, set_done, clash, clear;
  logic        head, done_irq_enable, se, lsbf, controller_select, idle_clock_level, data_pin_drive_enable;

  assign done_irq_enable  = ctrl[B_SIE];
  assign se   = ctrl[B_SE];
  assign lsbf = ctrl[B_LSBF];
  assign controller_select = ctrl[B_CONTROLLER_SELECT];
  assign idle_clock_level = ctrl[B_IDLE_CLOCK_LEVEL];
  assign data_pin_drive_enable = ctrl[B_DATA_PIN_DRIVE_ENABLE];

  // Pin inputs pass two flops before use
  ssd_pin_sync #(.WIDTH(3)) u_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .din      ({aux_sample_pin, sdio_in, sck_in}),
    .dout     (sync_q),
    .clk_rise (ext_rise),
    .clk_fall (ext_fall)
  );
  assign sck_s  = sync_q[0];
  assign sdio_s = sdio_oe ? sdio_q : sync_q[1];   // Own bit read unlagged
  assign aux_s  = sync_q[2];

  // Bus decode and transfer events
  always_comb
  begin
    acc      = psel & penable;
    wr       = acc & pwrite & pstrb[0];
    rd       = acc & ~pwrite;
    hit_ctrl = (paddr == ADDR_CTRL);
    hit_stat = (paddr == ADDR_STAT);
    hit_data = (paddr == ADDR_DATA);
    data_acc = acc & hit_data;
    unique case (ctrl[1:0])
      2'h0: half_m1 = HALF_M1_DIV16;
      2'h1: half_m1 = HALF_M1_DIV8;
      2'h2: half_m1 = HALF_M1_DIV4;
      2'h3: half_m1 = HALF_M1_DIV2;
    endcase
    // Master clock stands still in stop
    tick = (st == ST_SHIFT) & controller_select & se & ~stop_mode
         & (div_cnt == half_m1);
    // Slave edges keep coming in stop
    ev_rise = controller_select ? (tick & ~sck_q) : (ext_rise & se);
    ev_fall = controller_select ? (tick & sck_q) : (ext_fall & se);
    slv_start = (st == ST_IDLE) & se & ~controller_select
              & (idle_clock_level ? ev_fall : ev_rise);
    start = wr & hit_data & (st == ST_IDLE) & se & controller_select
          & ~sf & ~stop_mode;
    abort = ~se | (wr & hit_ctrl & controller_select & ~pwdata[B_CONTROLLER_SELECT]);
    act_rise = ev_rise & ((st == ST_SHIFT) | slv_start)
             & (bit_cnt < BITS);
    act_fall = ev_fall & ((st == ST_SHIFT) | slv_start)
             & (bit_cnt < BITS);
    tail_end = ev_fall & (st == ST_SHIFT) & (bit_cnt == BITS);
    set_done = act_rise & (bit_cnt == LAST_BIT);
    head     = lsbf ? shift_data_reg[0] : shift_data_reg[7];
  end

  // Shifter, bit counter and master clock next values
  always_comb
  begin
    next_st        = st;
    next_sdr       = shift_data_reg;
    next_sdio_q    = sdio_q;
    next_sck_q     = sck_q;
    next_fell_seen = fell_seen;
    next_bit_cnt   = bit_cnt;
    next_div_cnt   = div_cnt;
    if (abort)
    begin
      next_st        = ST_IDLE;
      next_bit_cnt   = 4'h0;
      next_fell_seen = 1'b0;
      next_div_cnt   = 4'h0;
      next_sck_q     = idle_clock_level;
    end
    else
    begin
      // Writes only land between transfers
      if (wr & hit_data & (st == ST_IDLE))
        next_sdr = pwdata[7:0];
      if (start | slv_start)
        next_st = ST_SHIFT;
      if (start)
        next_div_cnt = 4'h0;
      else if ((st == ST_SHIFT) & controller_select & ~stop_mode)
        next_div_cnt = tick ? 4'h0 : div_cnt + 4'h1;
      if (tick)
        next_sck_q = ~sck_q;
      else if (st == ST_IDLE)
        next_sck_q = idle_clock_level;
      // First bit waits on the pin before the first rise
      if ((st == ST_IDLE) & ~idle_clock_level & ~slv_start)
        next_sdio_q = head;
      if (act_fall)
      begin
        next_sdio_q    = head;
        next_fell_seen = 1'b1;
      end
      if (act_rise)
      begin
        next_sdr = lsbf ? {sdio_s, shift_data_reg[7:1]}
                        : {shift_data_reg[6:0], sdio_s};
        next_bit_cnt = bit_cnt + 4'h1;
        if (set_done & ~(controller_select & ~idle_clock_level))
        begin
          next_st        = ST_IDLE;
          next_bit_cnt   = 4'h0;
          next_fell_seen = 1'b0;
        end
      end
      // Master with low idle level returns the clock low
      if (tail_end)
      begin
        next_st        = ST_IDLE;
        next_bit_cnt   = 4'h0;
        next_fell_seen = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st        <= ST_IDLE;
      shift_data_reg       <= DATA_RESET;
      sdio_q    <= 1'b0;
      sck_q     <= 1'b1;
      fell_seen <= 1'b0;
      bit_cnt   <= 4'h0;
      div_cnt   <= 4'h0;
    end
    else
    begin
      st        <= next_st;
      shift_data_reg       <= next_sdr;
      sdio_q    <= next_sdio_q;
      sck_q     <= next_sck_q;
      fell_seen <= next_fell_seen;
      bit_cnt   <= next_bit_cnt;
      div_cnt   <= next_div_cnt;
    end
  end

  // Control, flags and read data next values
  always_comb
  begin
    next_ctrl = (wr & hit_ctrl) ? pwdata[7:0] : ctrl;
    next_aux_cap = set_done ? aux_s : aux_cap;
    clash = data_acc & (st == ST_SHIFT) & fell_seen
          & (bit_cnt < BITS);
    clear = data_acc & clr_arm;
    next_sf   = set_done | (sf & ~clear);
    next_access_clash_flag = clash | (access_clash_flag & ~clear);
    if (rd & hit_stat & prdata[B_SF])
      next_clr_arm = 1'b1;
    else if (clear)
      next_clr_arm = 1'b0;
    else
      next_clr_arm = clr_arm;
    next_prdata = prdata;
    // Read data sampled in the setup cycle; status and data reads feed the flag logic
    if (psel & ~penable)
    begin
      next_prdata = 32'h0000_0000;
      if (hit_ctrl)
        next_prdata[7:0] = ctrl;
      else if (hit_stat)
        next_prdata[7:0] = {sf, access_clash_flag, aux_cap, 5'h00};
      else if (hit_data)
        next_prdata[7:0] = shift_data_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= CTRL_RESET;
      sf      <= 1'b0;
      access_clash_flag    <= 1'b0;
      aux_cap <= 1'b0;
      clr_arm <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      ctrl    <= next_ctrl;
      sf      <= next_sf;
      access_clash_flag    <= next_access_clash_flag;
      aux_cap <= next_aux_cap;
      clr_arm <= next_clr_arm;
      prdata  <= next_prdata;
    end
  end

  // Bus answer, pins and port B direction view
  assign pready   = 1'b1;
  assign pslverr  = acc & ~(hit_ctrl | hit_stat | hit_data);
  assign sck_out  = sck_q;
  assign sck_oe   = se & controller_select;
  assign sdio_out = sdio_q;
  assign sdio_oe  = se & data_pin_drive_enable;
  // Stopped: request held back; flag kept for after exit
  assign irq = sf & done_irq_enable & ~stop_mode;

  // Override leaves the stored direction bits untouched
  always_comb
  begin
    portb_dir = portb_ddr;
    if (se)
    begin
      portb_dir[PB_AUX]  = 1'b0;
      portb_dir[PB_SCK]  = controller_select;
      portb_dir[PB_SDIO] = data_pin_drive_enable;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_stat_seen;
    rd && hit_stat && prdata[B_SF];
  endsequence
  sequence s_data_touch;
    data_acc && !set_done && !clash;
  endsequence

  a_aux_on_eighth: assert property (
    set_done |=> (aux_cap == $past(aux_s)) && sf)
    else $error("aux capture missed eighth rise");
  a_aux_reset_clear: assert property (
    disable iff (1'b0) $rose(presetn) |-> !aux_cap && !sf)
    else $error("aux capture not cleared by reset");
  a_busy_write_masked: assert property (
    (wr && hit_data && st == ST_SHIFT && !act_rise && !abort)
    |=> shift_data_reg == $past(shift_data_reg))
    else $error("data write landed during transfer");
  a_read_no_effect: assert property (
    (rd && hit_data && st == ST_SHIFT && !ev_rise && !ev_fall
     && !abort) |=> st == ST_SHIFT && $stable(bit_cnt))
    else $error("data read disturbed transfer");
  a_stop_pins_hold: assert property (
    (stop_mode && controller_select && se && !psel) |=> $stable(sck_out)
    && $stable(sdio_out))
    else $error("master pins moved in stop");
  a_stop_no_irq: assert property (
    stop_mode |-> !irq)
    else $error("request raised while stopped");
  a_stop_exit_irq: assert property (
    ($fell(stop_mode) && sf && done_irq_enable) |-> irq)
    else $error("no request after stop exit");
  a_abort_disable: assert property (
    (!se && !(wr && hit_ctrl)) |=> st == ST_IDLE && bit_cnt == 4'h0
    && !sck_oe && !sdio_oe)
    else $error("disable did not abort");
  a_done_clear_seq: assert property (
    s_stat_seen ##[2:3] s_data_touch |=> !sf && !access_clash_flag)
    else $error("flag clear sequence failed");
  a_clash_sets: assert property (
    clash |=> access_clash_flag ##0 st == ST_SHIFT || sf)
    else $error("clash flag not set");
  a_eight_bits: assert property (
    $rose(sf) |-> $past(bit_cnt) == LAST_BIT && $past(ev_rise))
    else $error("done not on eighth rise");
  a_portb_override: assert property (
    se |-> portb_dir[PB_SCK] == controller_select && portb_dir[PB_SDIO] == data_pin_drive_enable
    && portb_dir[7:6] == portb_ddr[7:6])
    else $error("port B override wrong");

endmodule // ssd_port
`default_nettype wire

// ==== inc/ssd_pkg.sv ====
// Shared constants and types of the synchronous serial data port
`default_nettype none
package ssd_pkg;

  // Register indices and APB byte addresses (index times four)
  localparam logic [7:0] IDX_CTRL  = 8'h0A;
  localparam logic [7:0] IDX_STAT  = 8'h0B;
  localparam logic [7:0] IDX_DATA  = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = IDX_CTRL << 2;
  localparam logic [7:0] ADDR_STAT = IDX_STAT << 2;
  localparam logic [7:0] ADDR_DATA = IDX_DATA << 2;

  // Control register fields
  localparam int B_SIE  = 7;
  localparam int B_SE   = 6;
  localparam int B_LSBF = 5;
  localparam int B_CONTROLLER_SELECT = 4;
  localparam int B_IDLE_CLOCK_LEVEL = 3;
  localparam int B_DATA_PIN_DRIVE_ENABLE = 2;
  localparam logic [7:0] CTRL_RESET = 8'h08;

  // Status register fields
  localparam int B_SF   = 7;
  localparam int B_ACCESS_CLASH_FLAG = 6;
  localparam int B_AUX  = 5;

  // Data register reset value
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Bits per transfer
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BITS     = 4'h8;

  // Master clock half periods minus one, in pclk cycles
  localparam logic [3:0] HALF_M1_DIV16 = 4'h7;
  localparam logic [3:0] HALF_M1_DIV8  = 4'h3;
  localparam logic [3:0] HALF_M1_DIV4  = 4'h1;
  localparam logic [3:0] HALF_M1_DIV2  = 4'h0;

  // Port B pin positions taken over while enabled
  localparam int PB_AUX  = 3;
  localparam int PB_SCK  = 4;
  localparam int PB_SDIO = 5;

  typedef enum logic {ST_IDLE, ST_SHIFT} ssd_state_t;

endpackage
`default_nettype wire

// ==== core/ssd_pin_sync.sv ====
// Two-stage pin synchroniser with edge detection on lane zero
`timescale 1ns/100ps
`default_nettype none
module ssd_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout,
  output logic                  clk_rise,
  output logic                  clk_fall
);

  logic [WIDTH-1:0] meta;
  logic             lane0_d;

  // One synchroniser per lane; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta[i] <= 1'b0;
          dout[i] <= 1'b0;
        end
        else
        begin
          meta[i] <= din[i];
          dout[i] <= meta[i];
        end
      end
    end
  endgenerate

  // Delayed copy of lane zero for edge finding
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lane0_d <= 1'b0;
    else
      lane0_d <= dout[0];
  end

  assign clk_rise = dout[0] & ~lane0_d;
  assign clk_fall = ~dout[0] & lane0_d;

endmodule // ssd_pin_sync
`default_nettype wire

// ==== sim/ssd_far_end.sv ====
// Far-end serial peripheral model: external master or slave on the link
`timescale 1ns/100ps
`default_nettype none
module ssd_far_end (
  input  wire logic sck_out,
  input  wire logic sck_oe,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  output logic      sck_line,
  output logic      sdio_line
);
  logic       p_sck = 1'b1;
  logic       p_en  = 1'b0;
  logic       p_bit = 1'b0;
  logic [7:0] rx    = 8'h00;

  // Resolved wires; data line is pulled up once released
  assign sck_line  = sck_oe ? sck_out : p_sck;
  assign sdio_line = sdio_oe ? sdio_out : (p_en ? p_bit : 1'b1);

  // Master role: clock idles high, 200 ns period, only within frames
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      p_sck = 1'b0;
      p_en  = 1'b1;
      p_bit = b[i];
      #100;
      p_sck = 1'b1;
      #100;
    end
    p_en = 1'b0;
  endtask

  // Slave role: capture data on each rising clock from the device
  always @(posedge sck_line)
    if (sck_oe)
      rx <= {rx[6:0], sdio_line};
endmodule // ssd_far_end
`default_nettype wire

// ==== sim/sync_serial_data_power_modes_bench.sv ====
// Self-checking bench of the serial data port with a far-end model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s expected %h seen %h", n, e, g); end end
module sync_serial_data_power_modes_bench
  import ssd_pkg::*;
;
  typedef struct packed {
    logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic x;
  } ssd_row_t;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, stop_mode, aux_sample_pin;
  logic [7:0]  paddr, portb_ddr, portb_dir;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, sck_out, sck_oe, sdio_out, sdio_oe, irq;
  logic        sck_line, sdio_line, er, hold;
  int          errors = 0;
  int          compares = 0;
  // Plain register traffic: write, read back, unmapped place
  ssd_row_t rows [8] = '{
    '{1'b1, ADDR_CTRL, 8'h48, 8'h00, 1'b0},
    '{1'b0, ADDR_CTRL, 8'h00, 8'h48, 1'b0},
    '{1'b1, ADDR_DATA, 8'h5A, 8'h00, 1'b0},
    '{1'b0, ADDR_DATA, 8'h00, 8'h5A, 1'b0},
    '{1'b0, 8'h40, 8'h00, 8'h00, 1'b1},
    '{1'b1, 8'h40, 8'h77, 8'h00, 1'b1},
    '{1'b0, ADDR_DATA, 8'h00, 8'h5A, 1'b0},
    '{1'b0, ADDR_STAT, 8'h00, 8'h00, 1'b0}};

  ssd_port i_ssd_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .sck_in(sck_line), .sck_out(sck_out),
    .sck_oe(sck_oe), .sdio_in(sdio_line), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .aux_sample_pin(aux_sample_pin),
    .portb_ddr(portb_ddr), .portb_dir(portb_dir), .irq(irq));
  ssd_far_end i_ssd_far_end (.sck_out(sck_out), .sck_oe(sck_oe),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sck_line(sck_line),
    .sdio_line(sdio_line));

  // Clock generator, 25 ns period
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // APB transfer: setup, then access held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      errors++;
      final_report();
    end
  endtask

  // Poll status until the done flag shows, bounded
  task automatic wait_done();
    int n;
    for (n = 0; n < 40; n++)
    begin
      apb(1'b0, ADDR_STAT, 8'h00);
      if (rd[B_SF] === 1'b1)
        break;
    end
    if (n == 40)
    begin
      errors++;
      final_report();
    end
  endtask

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    stop_mode = 1'b0;
    aux_sample_pin = 1'b0;
    portb_ddr = 8'hFF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        `CHK("rdata", rows[i].e, rd[7:0])
      `CHK("pslverr", rows[i].x, er)
    end
    `CHK("portb_dir", 8'hC7, portb_dir)
    // Slave byte with capture pin high
    apb(1'b1, ADDR_CTRL, 8'hC8);
    aux_sample_pin <= 1'b1;
    i_ssd_far_end.send(8'hA5);
    wait_done();
    `CHK("status", 8'hA0, rd[7:0])
    `CHK("irq", 1'b1, irq)
    apb(1'b0, ADDR_DATA, 8'h00);
    `CHK("data", 8'hA5, rd[7:0])
    apb(1'b0, ADDR_STAT, 8'h00);
    `CHK("done", 1'b0, rd[B_SF])
    // Data write in mid-transfer: ignored, clash flagged
    fork
      i_ssd_far_end.send(8'h3C);
      begin
        #700;
        apb(1'b1, ADDR_DATA, 8'hFF);
        apb(1'b0, ADDR_DATA, 8'h00);
      end
    join
    wait_done();
    `CHK("clash", 1'b1, rd[B_ACCESS_CLASH_FLAG])
    apb(1'b0, ADDR_DATA, 8'h00);
    `CHK("data", 8'h3C, rd[7:0])
    // Slave byte while stopped: no request until stop ends
    stop_mode <= 1'b1;
    i_ssd_far_end.send(8'h96);
    wait_done();
    `CHK("irq", 1'b0, irq)
    stop_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    apb(1'b0, ADDR_DATA, 8'h00);
    `CHK("data", 8'h96, rd[7:0])
    // Disable mid-transfer, then a full byte must still work
    fork
      i_ssd_far_end.send(8'hFF);
      begin
        #500;
        apb(1'b1, ADDR_CTRL, 8'h08);
        @(posedge pclk);
        `CHK("portb_dir", 8'hFF, portb_dir)
      end
    join
    apb(1'b0, ADDR_STAT, 8'h00);
    `CHK("done", 1'b0, rd[B_SF])
    apb(1'b1, ADDR_CTRL, 8'hC8);
    i_ssd_far_end.send(8'h11);
    wait_done();
    apb(1'b0, ADDR_DATA, 8'h00);
    `CHK("data", 8'h11, rd[7:0])
    // Master byte at fastest rate, halted by stop for a while
    apb(1'b1, ADDR_CTRL, 8'h5F);
    apb(1'b1, ADDR_DATA, 8'hC3);
    repeat (3) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    hold = sck_out;
    repeat (16) @(posedge pclk);
    `CHK("sck_out", hold, sck_out)
    stop_mode <= 1'b0;
    wait_done();
    `CHK("status", 8'hA0, rd[7:0])
    `CHK("far rx", 8'hC3, i_ssd_far_end.rx)
    apb(1'b0, ADDR_DATA, 8'h00);
    `CHK("data", 8'hC3, rd[7:0])
    // Disabled before stop: far-end clock is ignored
    apb(1'b1, ADDR_CTRL, 8'h08);
    stop_mode <= 1'b1;
    i_ssd_far_end.send(8'h5A);
    apb(1'b0, ADDR_STAT, 8'h00);
    `CHK("status", 8'h20, rd[7:0])
    stop_mode <= 1'b0;
    // Second reset in mid-run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    `CHK("portb_dir", 8'hFF, portb_dir)
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 8'h00);
    `CHK("ctrl", CTRL_RESET, rd[7:0])
    apb(1'b0, ADDR_STAT, 8'h00);
    `CHK("status", 8'h00, rd[7:0])
    final_report();
  end
endmodule // sync_serial_data_power_modes_bench
`default_nettype wire
